/* link_protect_status_irq_tb_top.sv */
`default_nettype none
module link_protect_status_irq_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic rst_n = 0;
  lps_pkg::lps_reg_req_s req;
  lps_pkg::lps_events_s evt = '0;
  lps_pkg::lps_levels_s lvl = 5'h10;
  logic [7:0] rdata, q;
  logic a_st, a_en, k_acc, kl_acc, k_stl, kl_stl, irq;
  int mismatches = 0;
  int check_count = 0;
  initial forever #20 clk = ~clk;
  lps_host host (.i_clk(clk), .i_rdata(rdata), .o_req(req));
  lps_status_irq dut (.i_clk(clk), .i_rst_n(rst_n), .i_reg(req),
    .o_reg_rdata(rdata), .i_evt(evt), .i_lvl(lvl), .o_auth_start(a_st),
    .o_auth_enabled(a_en), .o_key_accepted(k_acc),
    .o_key_list_accepted(kl_acc), .o_key_stall(k_stl),
    .o_key_list_stall(kl_stl), .o_irq(irq));
  // ****
  // Helpers
  // ****
  task automatic chk(string n, logic [7:0] s, e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rd(logic [7:0] a, e);
    host.access(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), q, e);
  endtask : rd
  task automatic wr(logic [7:0] a, d);
    host.access(1'b1, a, d, q);
  endtask : wr
  task automatic pulse(lps_pkg::lps_events_s e);
    @(posedge clk);
    #1 evt = e;
    @(posedge clk);
    #1 evt = '0;
  endtask : pulse
  task automatic setl(lps_pkg::lps_levels_s v);
    @(posedge clk);
    #1 lvl = v;
  endtask : setl
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    rd(8'hC6, 8'h00);
    rd(8'hC7, 8'h00);
    rd(8'hC3, 8'h00);
    rd(8'hC4, 8'h40);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_status();
    setl(5'h1C);
    pulse(7'h60);
    rd(8'hC4, 8'hF8);
    rd(8'hC4, 8'h68);
    rd(8'hC7, 8'h40);
    setl(5'h11);
    setl(5'h15);
    rd(8'hC7, 8'h00);
    setl(5'h1D);
    rd(8'hC7, 8'h40);
    $display("t_status done");
  endtask : t_status
  task automatic t_irq();
    wr(8'hC6, 8'h03);
    pulse(7'h04);
    chk("irq", 8'(irq), 8'h01);
    rd(8'hC4, 8'h69);
    rd(8'hC7, 8'h03);
    chk("irq", 8'(irq), 8'h00);
    wr(8'hC3, 8'h01);
    chk("start", 8'(a_st), 8'h01);
    rd(8'hC4, 8'h68);
    wr(8'hC3, 8'h00);
    rd(8'hC3, 8'h01);
    wr(8'hC6, 8'h02);
    pulse(7'h04);
    chk("irq", 8'(irq), 8'h00);
    rd(8'hC7, 8'h03);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_each();
    logic [6:0] ev[4] = '{7'h01, 7'h10, 7'h08, 7'h02};
    logic [7:0] pos[4] = '{8'h80, 8'h10, 8'h08, 8'h04};
    wr(8'hC6, 8'hFF);
    foreach (ev[i]) begin
      pulse(ev[i]);
      chk("irq", 8'(irq), 8'h01);
      rd(8'hC7, pos[i] | 8'h01);
    end
    setl(5'h0D);
    @(posedge clk);
    #1;
    chk("irq", 8'(irq), 8'h01);
    rd(8'hC4, 8'h2C);
    rd(8'hC7, 8'h21);
    setl(5'h1D);
    $display("t_each done");
  endtask : t_each
  task automatic t_keys();
    chk("list stall", 8'(kl_stl), 8'h01);
    wr(8'hC3, 8'h20);
    chk("list ok", 8'(kl_acc), 8'h01);
    chk("list stall", 8'(kl_stl), 8'h00);
    pulse(7'h08);
    chk("key stall", 8'(k_stl), 8'h01);
    // The host accepts only once the key vector has been checked
    wr(8'hC3, 8'h10);
    chk("key stall", 8'(k_stl), 8'h00);
    chk("key ok", 8'(k_acc), 8'h01);
    pulse(7'h08);
    chk("key ok", 8'(k_acc), 8'h00);
    pulse(7'h02);
    chk("key stall", 8'(k_stl), 8'h00);
    setl(5'h1F);
    pulse(7'h08);
    chk("key stall", 8'(k_stl), 8'h00);
    rd(8'hC4, 8'h6A);
    $display("t_keys done");
  endtask : t_keys
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  // Whole run is about a hundred cycles; this leaves a wide margin
  initial begin
    #100000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1;
    t_reset();
    t_status();
    t_irq();
    t_each();
    t_keys();
    close_out();
  end
endmodule : link_protect_status_irq_tb_top
`default_nettype wire

/* lps_edge.sv */
`default_nettype none

// Rising edge detector on already synchronous levels
module lps_edge #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_level,
  output logic [WIDTH-1:0] o_rise
);

  logic [WIDTH-1:0] prev;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev <= '0;
    end else begin
      prev <= i_level;
    end
  end

  assign o_rise = i_level & ~prev;

endmodule : lps_edge

`default_nettype wire

/* lps_host.sv */
`default_nettype none
module lps_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output lps_pkg::lps_reg_req_s o_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_req = '0;
  // One strobe per access; the request stands for exactly one edge
  task automatic access(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
    @(posedge i_clk);
    #1 o_req = '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge i_clk);
    #1 o_req = '0;
    q = i_rdata;
  endtask : access
endmodule : lps_host
`default_nettype wire

/* lps_pkg.sv */
`default_nettype none

package lps_pkg;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [7:0] ADDR_PROTECTION_CONTROL = 8'hC3;
  localparam logic [7:0] ADDR_LINK_PROTECT_STATUS = 8'hC4;
  localparam logic [7:0] ADDR_PROTECT_IRQ_CONTROL = 8'hC6;
  localparam logic [7:0] ADDR_PROTECT_IRQ_STATUS = 8'hC7;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [7:0] RST_LINK_PROTECT_STATUS = 8'h00;
  localparam logic [7:0] RST_PROTECT_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] RST_PROTECT_IRQ_STATUS = 8'h00;
  localparam logic [7:0] RST_PROTECTION_CONTROL = 8'h00;

  // ***************************************************************
  // Status register fields
  // ***************************************************************
  localparam int STS_LINK_ERROR = 7;
  localparam int STS_REMOTE_IRQ_N = 6;
  localparam int STS_LOCK = 5;
  localparam int STS_HOTPLUG = 4;
  localparam int STS_PRESENT = 3;
  localparam int STS_KEY_LIST_READY = 2;
  localparam int STS_KEY_VECTOR_READY = 1;
  localparam int STS_AUTHENTICATED = 0;

  // ***************************************************************
  // Interrupt control and status fields (same positions)
  // ***************************************************************
  localparam int IRQ_INDIRECT_DONE = 7;
  localparam int IRQ_PRESENT = 6;
  localparam int IRQ_DOWNSTREAM = 5;
  localparam int IRQ_KEY_LIST = 4;
  localparam int IRQ_KEY_VECTOR = 3;
  localparam int IRQ_AUTH_FAIL = 2;
  localparam int IRQ_AUTH_PASS = 1;
  localparam int IRQ_GLOBAL = 0;

  // ***************************************************************
  // Control register fields
  // ***************************************************************
  localparam int CTL_KEY_LIST_ACCEPTED = 5;
  localparam int CTL_KEY_ACCEPTED = 4;
  localparam int CTL_ENABLE_RESTART = 0;

  // One-cycle event strobes from the authentication engine
  typedef struct packed {
    logic link_error;
    logic hotplug;
    logic key_list_loaded;
    logic key_vector_loaded;
    logic auth_pass;
    logic auth_fail;
    logic indirect_done;
  } lps_events_s;

  // Levels reported by the link
  typedef struct packed {
    logic remote_irq_input_n;
    logic downstream_lock;
    logic receiver_present;
    logic is_repeater;
    logic present_needs_lock;
  } lps_levels_s;

  // Register access port of the serial control bus
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } lps_reg_req_s;

endpackage : lps_pkg

`default_nettype wire

/* lps_status_irq.sv */
`default_nettype none

// What this block does
// - Link error sticky, cleared by status read
// - Bit 6 mirrors remote interrupt, active low
// - Bit 5 mirrors downstream lock
// - Hot plug sticky, cleared by status read
// - Bit 3 mirrors receiver present
// - List ready stalls until list accepted
// - Key ready stalls non-repeater; accept/fail clear
// - Authenticated clears on loss or restart
// - Enable bit 7: indirect access done
// - Enable bit 6: receiver present, optionally lock
// - Enable bit 5: downstream interrupt propagation
// - Enable bits 4,3: list, key ready
// - Enable bit 2: auth failure or loss
// - Enable bit 1: auth pass
// - Enable bit 0 gates interrupt output
// - Pending bits mirror enable positions
// - Summary bit: any enabled event pending
// - Write 1 starts/restarts; read shows enabled
module lps_status_irq (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire lps_pkg::lps_reg_req_s i_reg,
  output logic [7:0] o_reg_rdata,
  input wire lps_pkg::lps_events_s i_evt,
  input wire lps_pkg::lps_levels_s i_lvl,
  output logic o_auth_start,
  output logic o_auth_enabled,
  output logic o_key_accepted,
  output logic o_key_list_accepted,
  output logic o_key_stall,
  output logic o_key_list_stall,
  output logic o_irq
);

  // ***************************************************************
  // Register decode
  // ***************************************************************
  logic wr_ctl;
  logic wr_icr;
  logic rd_sts;
  logic rd_isr;

  assign wr_ctl =
    i_reg.wr && (i_reg.addr == lps_pkg::ADDR_PROTECTION_CONTROL);
  assign wr_icr =
    i_reg.wr && (i_reg.addr == lps_pkg::ADDR_PROTECT_IRQ_CONTROL);
  assign rd_sts =
    i_reg.rd && (i_reg.addr == lps_pkg::ADDR_LINK_PROTECT_STATUS);
  assign rd_isr =
    i_reg.rd && (i_reg.addr == lps_pkg::ADDR_PROTECT_IRQ_STATUS);

  logic restart;
  logic list_accept_wr;
  logic key_accept_wr;

  assign restart = wr_ctl && i_reg.wdata[lps_pkg::CTL_ENABLE_RESTART];
  assign list_accept_wr =
    wr_ctl && i_reg.wdata[lps_pkg::CTL_KEY_LIST_ACCEPTED];
  assign key_accept_wr = wr_ctl && i_reg.wdata[lps_pkg::CTL_KEY_ACCEPTED];

  // ***************************************************************
  // Control bits
  // ***************************************************************
  logic enabled;
  logic key_accepted;

  // Writing 0 leaves enable alone; nothing here turns it off again
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enabled <= lps_pkg::RST_PROTECTION_CONTROL[lps_pkg::CTL_ENABLE_RESTART];
    end else if (restart) begin
      enabled <= 1'b1;
    end
  end

  // Cleared when the next key vector arrives; a fresh load beats a write
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      key_accepted <=
        lps_pkg::RST_PROTECTION_CONTROL[lps_pkg::CTL_KEY_ACCEPTED];
    end else if (i_evt.key_vector_loaded) begin
      key_accepted <= 1'b0;
    end else if (key_accept_wr) begin
      key_accepted <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_auth_start <= 1'b0;
    end else begin
      o_auth_start <= restart;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_key_list_accepted <= 1'b0;
    end else begin
      o_key_list_accepted <= list_accept_wr;
    end
  end

  assign o_auth_enabled = enabled;
  assign o_key_accepted = key_accepted;

  // ***************************************************************
  // Status flags
  // ***************************************************************
  // Each flag is a cell of its own, so every clear source stays visible
  logic link_error_flag;
  logic downstream_hotplug_flag;
  logic key_list_ready;
  logic key_vector_ready;
  logic authenticated_flag;
  logic key_vector_clr;
  logic authenticated_clr;

  assign key_vector_clr = key_accept_wr || i_evt.auth_fail;
  assign authenticated_clr = i_evt.auth_fail || restart;

  lps_sticky #(
    .WIDTH(1)
  ) u_link_error (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_set(i_evt.link_error),
    .i_clr(rd_sts),
    .o_flag(link_error_flag)
  );

  lps_sticky #(
    .WIDTH(1)
  ) u_hotplug (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_set(i_evt.hotplug),
    .i_clr(rd_sts),
    .o_flag(downstream_hotplug_flag)
  );

  lps_sticky #(
    .WIDTH(1)
  ) u_key_list (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_set(i_evt.key_list_loaded),
    .i_clr(list_accept_wr),
    .o_flag(key_list_ready)
  );

  lps_sticky #(
    .WIDTH(1)
  ) u_key_vector (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_set(i_evt.key_vector_loaded),
    .i_clr(key_vector_clr),
    .o_flag(key_vector_ready)
  );

  lps_sticky #(
    .WIDTH(1)
  ) u_authenticated (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_set(i_evt.auth_pass),
    .i_clr(authenticated_clr),
    .o_flag(authenticated_flag)
  );

  // Authentication engine holds while list ready, or key ready on a non-repeater, is set
  assign o_key_list_stall = key_list_ready;
  assign o_key_stall = key_vector_ready && !i_lvl.is_repeater;

  logic [7:0] status;

  always_comb begin
    status = lps_pkg::RST_LINK_PROTECT_STATUS;
    status[lps_pkg::STS_LINK_ERROR] = link_error_flag;
    status[lps_pkg::STS_REMOTE_IRQ_N] = i_lvl.remote_irq_input_n;
    status[lps_pkg::STS_LOCK] = i_lvl.downstream_lock;
    status[lps_pkg::STS_HOTPLUG] = downstream_hotplug_flag;
    status[lps_pkg::STS_PRESENT] = i_lvl.receiver_present;
    status[lps_pkg::STS_KEY_LIST_READY] = key_list_ready;
    status[lps_pkg::STS_KEY_VECTOR_READY] = key_vector_ready;
    status[lps_pkg::STS_AUTHENTICATED] = authenticated_flag;
  end

  // ***************************************************************
  // Interrupt events
  // ***************************************************************
  // Presence may be qualified by lock, so the edge is taken after that
  logic present_qual;
  logic remote_irq_active;
  logic present_rise;
  logic remote_irq_rise;

  assign present_qual = i_lvl.receiver_present &&
    (!i_lvl.present_needs_lock || i_lvl.downstream_lock);
  // Active high copy, so a falling input level becomes an event
  assign remote_irq_active = !i_lvl.remote_irq_input_n;

  lps_edge #(
    .WIDTH(1)
  ) u_present_edge (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_level(present_qual),
    .o_rise(present_rise)
  );

  lps_edge #(
    .WIDTH(1)
  ) u_remote_irq_edge (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_level(remote_irq_active),
    .o_rise(remote_irq_rise)
  );

  logic [7:0] icr;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      icr <= lps_pkg::RST_PROTECT_IRQ_CONTROL;
    end else if (wr_icr) begin
      icr <= i_reg.wdata;
    end
  end

  logic [7:1] irq_set;

  always_comb begin
    irq_set = '0;
    irq_set[lps_pkg::IRQ_INDIRECT_DONE] = i_evt.indirect_done;
    irq_set[lps_pkg::IRQ_PRESENT] = present_rise;
    irq_set[lps_pkg::IRQ_DOWNSTREAM] = remote_irq_rise;
    irq_set[lps_pkg::IRQ_KEY_LIST] = i_evt.key_list_loaded;
    irq_set[lps_pkg::IRQ_KEY_VECTOR] = i_evt.key_vector_loaded;
    irq_set[lps_pkg::IRQ_AUTH_FAIL] = i_evt.auth_fail;
    irq_set[lps_pkg::IRQ_AUTH_PASS] = i_evt.auth_pass;
  end

  // Pending bits latch regardless of enable so software can poll them
  logic [7:1] pending;

  lps_sticky #(
    .WIDTH(7)
  ) u_pend (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_set(irq_set),
    .i_clr({7{rd_isr}}),
    .o_flag(pending)
  );

  logic summary;

  assign summary = |(pending & icr[7:1]);
  assign o_irq = icr[lps_pkg::IRQ_GLOBAL] && summary;

  // ***************************************************************
  // Read data
  // ***************************************************************
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    case (i_reg.addr)
      lps_pkg::ADDR_PROTECTION_CONTROL: begin
        next_rdata[lps_pkg::CTL_ENABLE_RESTART] = enabled;
        next_rdata[lps_pkg::CTL_KEY_ACCEPTED] = key_accepted;
      end
      lps_pkg::ADDR_LINK_PROTECT_STATUS: begin
        next_rdata = status;
      end
      lps_pkg::ADDR_PROTECT_IRQ_CONTROL: begin
        next_rdata = icr;
      end
      lps_pkg::ADDR_PROTECT_IRQ_STATUS: begin
        next_rdata = {pending, summary};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg.rd) begin
      o_reg_rdata <= next_rdata;
    end
  end

endmodule : lps_status_irq

`default_nettype wire

/* lps_status_irq_checker.sv */
`default_nettype none
module lps_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire lps_pkg::lps_reg_req_s i_reg,
  input wire logic [7:0] o_reg_rdata,
  input wire lps_pkg::lps_events_s i_evt,
  input wire lps_pkg::lps_levels_s i_lvl,
  input wire logic o_auth_start,
  input wire logic o_auth_enabled,
  input wire logic o_key_accepted,
  input wire logic o_key_list_accepted,
  input wire logic o_key_stall,
  input wire logic o_key_list_stall,
  input wire logic o_irq
);
  logic gen_en;
  logic c3w;
  assign c3w = i_reg.wr && i_reg.addr == lps_pkg::ADDR_PROTECTION_CONTROL;
  // Shadow of the global enable, tracked from writes alone
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gen_en <= 1'b0;
    end else if (i_reg.wr &&
                 i_reg.addr == lps_pkg::ADDR_PROTECT_IRQ_CONTROL) begin
      gen_en <= i_reg.wdata[0];
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_start_pulse: assert property (c3w && i_reg.wdata[0] |=>
    o_auth_start ##1 !o_auth_start) else $error("start pulse wrong");
  a_no_start: assert property (!(c3w && i_reg.wdata[0]) |=>
    !o_auth_start) else $error("stray start");
  a_enable_kept: assert property (o_auth_enabled |=> o_auth_enabled)
    else $error("enable lost");
  a_key_cleared: assert property (i_evt.key_vector_loaded |=>
    !o_key_accepted) else $error("key accept not cleared");
  a_list_raise: assert property (i_evt.key_list_loaded |=>
    o_key_list_stall) else $error("list stall missing");
  a_list_drop: assert property (c3w && i_reg.wdata[5] &&
    !i_evt.key_list_loaded |=> !o_key_list_stall) else $error("list stall");
  a_key_raise: assert property (i_evt.key_vector_loaded &&
    !i_lvl.is_repeater |=> o_key_stall) else $error("key stall missing");
  a_fail_drop: assert property (i_evt.auth_fail &&
    !i_evt.key_vector_loaded |=> !o_key_stall) else $error("key stall");
  a_irq_gated: assert property (!gen_en |-> !o_irq)
    else $error("irq without global enable");
  cover property (o_irq);
  cover property (o_key_stall);
  cover property (o_key_list_stall);
endmodule : lps_chk
bind lps_status_irq lps_chk u_chk (.*);
`default_nettype wire

/* lps_sticky.sv */
`default_nettype none

// Sticky flags: a set in the same cycle as a clear wins
module lps_sticky #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_set,
  input wire logic [WIDTH-1:0] i_clr,
  output logic [WIDTH-1:0] o_flag
);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flag <= '0;
    end else begin
      o_flag <= i_set | (o_flag & ~i_clr);
    end
  end

endmodule : lps_sticky

`default_nettype wire
